// ### pkg/rail_sup_pkg.sv
// rail_sup_pkg: offsets, field layouts, reset values and timing constants
// for the io rail and high-voltage regulator supervisor.
// assumes a 200 MHz clock and a 32-bit apb register bus.
package rail_sup_pkg;
   localparam int unsigned CLK_MHZ = 200;
   // deglitch times, typical values in nanoseconds
   localparam int unsigned OV_T0_NS = 25000;
   localparam int unsigned OV_T1_NS = 45000;
   localparam int unsigned UV_T0_NS = 5000;
   localparam int unsigned UV_T1_NS = 15000;
   localparam int unsigned UV_T2_NS = 25000;
   localparam int unsigned UV_T3_NS = 40000;
   localparam int unsigned OV_C0 = OV_T0_NS * CLK_MHZ / 1000;
   localparam int unsigned OV_C1 = OV_T1_NS * CLK_MHZ / 1000;
   localparam int unsigned UV_C0 = UV_T0_NS * CLK_MHZ / 1000;
   localparam int unsigned UV_C1 = UV_T1_NS * CLK_MHZ / 1000;
   localparam int unsigned UV_C2 = UV_T2_NS * CLK_MHZ / 1000;
   localparam int unsigned UV_C3 = UV_T3_NS * CLK_MHZ / 1000;
   localparam int unsigned CNT_W = 14;

   // register byte addresses
   localparam logic [11:0] ADDR_CFG = 12'h000;
   localparam logic [11:0] ADDR_REACT = 12'h004;
   localparam logic [11:0] ADDR_THR = 12'h008;
   localparam logic [11:0] ADDR_STAT = 12'h00C;
   localparam logic [11:0] ADDR_MASK = 12'h010;
   localparam logic [11:0] ADDR_LIVE = 12'h014;

   // cfg word layout
   localparam int unsigned CFG_SRC_LSB = 0;   // io source, 3 bits
   localparam int unsigned CFG_IO_NOM = 3;
   localparam int unsigned CFG_HV_MODE = 4;   // 1 = switch mode
   localparam int unsigned CFG_HV_NOM = 5;    // 1 = 3.3 V (linear only)
   localparam int unsigned CFG_IO_OVDG = 6;
   localparam int unsigned CFG_IO_UVDG_LSB = 7;
   localparam int unsigned CFG_HV_OVDG = 9;
   localparam int unsigned CFG_HV_UVDG_LSB = 10;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;

   // reaction word: io ov [1:0], io uv [3:2], hv ov [5:4], hv uv [7:6]
   localparam logic [31:0] REACT_RST = 32'h0000_0066;
   // threshold word: io ov, io uv, hv ov, hv uv codes, 4 bits each
   localparam logic [31:0] THR_RST = 32'h0000_0000;

   // status bits
   localparam int unsigned ST_IO_OV = 0;
   localparam int unsigned ST_IO_UV = 1;
   localparam int unsigned ST_HV_OV = 2;
   localparam int unsigned ST_HV_UV = 3;

   // io source encodings; code 7 means external regulator
   localparam logic [2:0] SRC_EXT = 3'h7;
   localparam int unsigned NREG = 7;

   localparam logic [1:0] REACT_NONE = 2'h0;
   localparam logic [1:0] REACT_FS = 2'h1;

   typedef enum logic [2:0] {
      DG_IDLE = 3'b001,
      DG_WAIT = 3'b010,
      DG_FAULT = 3'b100
   } dg_state_t;
endpackage

// ### pkg/deglitch_if.sv
// deglitch_if: raw comparator level, selected count and filtered result.
// assumes one clock domain shared by both ends.
`timescale 1ns/10ps
interface deglitch_if;
   import rail_sup_pkg::*;
   logic raw;
   logic [CNT_W-1:0] limit;
   logic fault;
   modport filt (input raw, input limit, output fault);
   modport user (output raw, output limit, input fault);
endinterface

// ### rtl/rail_deglitch.sv
// rail_deglitch: persistence filter for one comparator output.
// assumes raw is synchronous to i_clk and limit stays at least 1.
`timescale 1ns/10ps
module rail_deglitch
   import rail_sup_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   deglitch_if.filt dg
);
   dg_state_t state_q;
   logic [CNT_W-1:0] cnt_q;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= DG_IDLE;
         cnt_q <= '0;
      end else begin
         case (state_q)
            DG_IDLE: begin
               cnt_q <= CNT_W'(1);
               if (dg.raw) begin
                  state_q <= DG_WAIT;
               end
            end
            DG_WAIT: begin
               // restart on any drop of the condition
               if (!dg.raw) begin
                  state_q <= DG_IDLE; // R15
               end else if (cnt_q >= dg.limit) begin
                  state_q <= DG_FAULT; // R15
               end else begin
                  cnt_q <= cnt_q + CNT_W'(1);
               end
            end
            DG_FAULT: begin
               if (!dg.raw) begin
                  state_q <= DG_IDLE;
               end
            end
            default: state_q <= DG_IDLE;
         endcase
      end
   end

   assign dg.fault = (state_q == DG_FAULT);

   chk_fault_needs_raw: assert property (@(posedge i_clk)
      disable iff (!i_resetn) dg.fault |-> $past(dg.raw)) // R15
      else $error("fault without persisting condition");
endmodule

// ### rtl/io_and_hv_rail_supervisor.sv
// io_and_hv_rail_supervisor: filtered fault reaction for the io rail
// monitor and the high-voltage linear regulator monitor, apb registers.
// assumes comparator levels are synchronous to i_clk; the analog side
// applies threshold, nominal and reference outputs.
//
// Behaviour
// R01: io ov switches off the regulator named by the 3-bit source field.
// R02: an external source is never switched off, only its flag is set; the code still drives the io ov pin reaction set by react bits [1:0].
// R03: io ov reaction 00 none, 01 fail-safe, 1x both; reset gives 1x.
// R04: io uv reaction 00 none, 01 fail-safe, 1x both; reset gives 01.
// R05: io ov threshold is a 4-bit code from +2.5% to +10% in 0.5% steps.
// R06: io uv threshold is a 4-bit code from -2.5% to -10% in 0.5% steps.
// R07: io ov deglitch is 25 or 45 us by one bit, uv 5/15/25/40 us by two.
// R08: one bit selects 1.8 V or 3.3 V as the io nominal level.
// R09: one bit sets hv monitor mode; switch mode tracks the core dac.
// R10: switch mode forces 0.8 V; linear mode picks 0.8 V or 3.3 V by a bit.
// R11: hv has separate 2-bit ov and uv reaction fields, restored on reset.
// R12: hv ov and uv thresholds come from two 4-bit codes in one word.
// R13: hv ov deglitch is 25 or 45 us, uv 5/15/25/40 us.
// R14: hv reaction codes map like io; ov defaults to both, uv to fail-safe.
// R15: a fault counts only after lasting the deglitch time; a drop restarts.
// R16: the switched-off regulator stays off until the overvoltage is gone.
// R17: ov and uv flags are set for the host whatever the pin reaction.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module io_and_hv_rail_supervisor
   import rail_sup_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_io_ov_cmp,
   input wire logic i_io_uv_cmp,
   input wire logic i_hv_ov_cmp,
   input wire logic i_hv_uv_cmp,
   input wire logic [7:0] i_core_dac,
   output logic [NREG-1:0] o_reg_off,
   output logic o_system_reset_out_n,
   output logic o_failsafe_out_n,
   output logic o_irq,
   output logic [3:0] o_io_ov_threshold_code,
   output logic [3:0] o_io_uv_threshold_code,
   output logic [3:0] o_hv_ov_threshold_code,
   output logic [3:0] o_hv_uv_threshold_code,
   output logic o_io_nominal_3v3,
   output logic o_hv_nominal_3v3,
   output logic o_hv_track_dac,
   output logic [7:0] o_hv_reference
);
   logic [31:0] cfg_q, react_q, thr_q;
   logic [3:0] stat_q, mask_q;
   logic [NREG-1:0] reg_off_q;
   logic rst_n_q, fs_n_q;
   logic [31:0] rdata_d;
   logic wr, err_d;
   logic [3:0] flt;
   logic [2:0] io_src;
   logic [1:0] io_ov_r, io_uv_r, hv_ov_r, hv_uv_r, act;

   function automatic logic [CNT_W-1:0] ov_cnt(input logic sel);
      ov_cnt = sel ? CNT_W'(OV_C1) : CNT_W'(OV_C0);
   endfunction

   function automatic logic [CNT_W-1:0] uv_cnt(input logic [1:0] sel);
      case (sel)
         2'h0: uv_cnt = CNT_W'(UV_C0);
         2'h1: uv_cnt = CNT_W'(UV_C1);
         2'h2: uv_cnt = CNT_W'(UV_C2);
         default: uv_cnt = CNT_W'(UV_C3);
      endcase
   endfunction

   // reaction decode: bit0 fail-safe, bit1 reset
   function automatic logic [1:0] react(input logic [1:0] sel,
                                        input logic f);
      react = {f && sel[1], f && (sel != REACT_NONE)};
   endfunction

   deglitch_if dg_io_ov ();
   deglitch_if dg_io_uv ();
   deglitch_if dg_hv_ov ();
   deglitch_if dg_hv_uv ();

   assign dg_io_ov.raw = i_io_ov_cmp;
   assign dg_io_uv.raw = i_io_uv_cmp;
   assign dg_hv_ov.raw = i_hv_ov_cmp;
   assign dg_hv_uv.raw = i_hv_uv_cmp;
   assign dg_io_ov.limit = ov_cnt(cfg_q[CFG_IO_OVDG]); // R07
   assign dg_io_uv.limit = uv_cnt(cfg_q[CFG_IO_UVDG_LSB +: 2]); // R07
   assign dg_hv_ov.limit = ov_cnt(cfg_q[CFG_HV_OVDG]); // R13
   assign dg_hv_uv.limit = uv_cnt(cfg_q[CFG_HV_UVDG_LSB +: 2]); // R13

   rail_deglitch u_io_ov (.i_clk(i_clk), .i_resetn(i_resetn),
      .dg(dg_io_ov.filt));
   rail_deglitch u_io_uv (.i_clk(i_clk), .i_resetn(i_resetn),
      .dg(dg_io_uv.filt));
   rail_deglitch u_hv_ov (.i_clk(i_clk), .i_resetn(i_resetn),
      .dg(dg_hv_ov.filt));
   rail_deglitch u_hv_uv (.i_clk(i_clk), .i_resetn(i_resetn),
      .dg(dg_hv_uv.filt));

   assign flt[ST_IO_OV] = dg_io_ov.fault;
   assign flt[ST_IO_UV] = dg_io_uv.fault;
   assign flt[ST_HV_OV] = dg_hv_ov.fault;
   assign flt[ST_HV_UV] = dg_hv_uv.fault;

   assign io_src = cfg_q[CFG_SRC_LSB +: 3];
   assign io_ov_r = react_q[1:0];
   assign io_uv_r = react_q[3:2];
   assign hv_ov_r = react_q[5:4];
   assign hv_uv_r = react_q[7:6];

   // apb: zero wait states, unmapped addresses answer with pslverr
   assign o_pready = 1'b1;
   assign wr = i_psel && i_penable && i_pwrite;

   always_comb begin
      rdata_d = 32'h0000_0000;
      err_d = 1'b0;
      case (i_paddr)
         ADDR_CFG: rdata_d = cfg_q;
         ADDR_REACT: rdata_d = react_q;
         ADDR_THR: rdata_d = thr_q;
         ADDR_STAT: rdata_d = {28'h0, stat_q};
         ADDR_MASK: rdata_d = {28'h0, mask_q};
         ADDR_LIVE: rdata_d = {21'h0, reg_off_q, flt};
         default: err_d = 1'b1;
      endcase
   end

   assign o_pslverr = i_psel && i_penable && err_d;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         o_prdata <= rdata_d;
      end
   end

   // configuration words; reaction fields come back to defaults on reset
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cfg_q <= CFG_RST;
         react_q <= REACT_RST; // R03 R04 R11 R14
         thr_q <= THR_RST;
         mask_q <= 4'h0;
      end else if (wr) begin
         case (i_paddr)
            ADDR_CFG: cfg_q <= {20'h0, i_pwdata[11:0]};
            ADDR_REACT: react_q <= {24'h0, i_pwdata[7:0]};
            ADDR_THR: thr_q <= {16'h0, i_pwdata[15:0]};
            ADDR_MASK: mask_q <= i_pwdata[3:0];
            default: ;
         endcase
      end
   end

   // sticky flags, set wins over write-one-to-clear
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         stat_q <= 4'h0;
      end else begin
         stat_q <= (stat_q & ~((wr && i_paddr == ADDR_STAT) ?
            i_pwdata[3:0] : 4'h0)) | flt; // R17
      end
   end

   assign o_irq = |(stat_q & mask_q);

   // switch-off held while the filtered overvoltage lasts
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         reg_off_q <= '0;
      end else begin
         for (int i = 0; i < NREG; i++) begin
            reg_off_q[i] <= flt[ST_IO_OV] && io_src != SRC_EXT
               && io_src == 3'(i); // R01 R02 R16
         end
      end
   end
   assign o_reg_off = reg_off_q;

   // pin reaction, outputs active low
   assign act = react(io_ov_r, flt[ST_IO_OV]) | react(io_uv_r, flt[ST_IO_UV])
      | react(hv_ov_r, flt[ST_HV_OV])
      | react(hv_uv_r, flt[ST_HV_UV]); // R03 R04 R11 R14
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_n_q <= 1'b1;
         fs_n_q <= 1'b1;
      end else begin
         fs_n_q <= !act[0];
         rst_n_q <= !act[1];
      end
   end
   assign o_system_reset_out_n = rst_n_q;
   assign o_failsafe_out_n = fs_n_q;

   assign o_io_ov_threshold_code = thr_q[3:0]; // R05
   assign o_io_uv_threshold_code = thr_q[7:4]; // R06
   assign o_hv_ov_threshold_code = thr_q[11:8]; // R12
   assign o_hv_uv_threshold_code = thr_q[15:12]; // R12
   assign o_io_nominal_3v3 = cfg_q[CFG_IO_NOM]; // R08
   assign o_hv_track_dac = cfg_q[CFG_HV_MODE]; // R09
   // switch mode is only valid at 0.8 V
   assign o_hv_nominal_3v3 = !cfg_q[CFG_HV_MODE]
      && cfg_q[CFG_HV_NOM]; // R10
   assign o_hv_reference = cfg_q[CFG_HV_MODE] ? i_core_dac
      : 8'h00; // R09

   chk_ext_no_off: assert property (@(posedge i_clk) disable iff (!i_resetn)
      io_src == SRC_EXT |=> o_reg_off == '0) // R02
      else $error("external source switched off");
   chk_ov_switch_off: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      flt[ST_IO_OV] && io_src != SRC_EXT && $stable(io_src)
      |=> o_reg_off[$past(io_src)]) // R01
      else $error("overvoltage regulator not switched off");
   chk_off_held_ov: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      !flt[ST_IO_OV] |=> o_reg_off == '0) // R16
      else $error("switch-off without overvoltage");
   chk_flag_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
      flt[ST_HV_UV] |=> stat_q[ST_HV_UV]) // R17
      else $error("flag not set on fault");
   chk_io_ov_both: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      flt[ST_IO_OV] && io_ov_r[1] |=> !o_system_reset_out_n
      && !o_failsafe_out_n) // R03
      else $error("io ov reaction missing");
   chk_io_uv_fs: assert property (@(posedge i_clk) disable iff (!i_resetn)
      flt[ST_IO_UV] && io_uv_r != REACT_NONE |=> !o_failsafe_out_n) // R04
      else $error("io uv fail-safe missing");
   chk_hv_no_react: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      flt == 4'h0 |=> o_system_reset_out_n && o_failsafe_out_n) // R11
      else $error("reaction without fault");
   chk_hv_sw_nom: assert property (@(posedge i_clk) disable iff (!i_resetn)
      cfg_q[CFG_HV_MODE] |-> !o_hv_nominal_3v3) // R10
      else $error("switch mode at 3.3 V");
   chk_ov_deglitch: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      $rose(flt[ST_IO_OV]) |-> $past(i_io_ov_cmp, 8)) // R07
      else $error("io ov flagged too soon");
   chk_hv_uv_reset: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      flt[ST_HV_UV] && hv_uv_r[1] |=> !o_system_reset_out_n) // R14
      else $error("hv uv reset missing");

   cov_io_ov_off: cover property (@(posedge i_clk) disable iff (!i_resetn)
      |o_reg_off);
   cov_irq: cover property (@(posedge i_clk) disable iff (!i_resetn)
      $rose(o_irq));
   cov_reset_out: cover property (@(posedge i_clk)
      disable iff (!i_resetn) $fell(o_system_reset_out_n));
   cov_hv_switch: cover property (@(posedge i_clk)
      disable iff (!i_resetn) flt[ST_HV_OV] && o_hv_track_dac);
endmodule

// ### dv/host_mcu_model.sv
// host_mcu_model: far-side microcontroller that counts the reset and
// fail-safe requests it receives from the supervisor.
// assumes both pins are active low and synchronous to i_clk.
`timescale 1ns/10ps
module host_mcu_model (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_system_reset_out_n,
   input wire logic i_failsafe_out_n,
   output logic [7:0] o_rst_count,
   output logic [7:0] o_fs_count
);
   logic rst_prev_q;
   logic fs_prev_q;
   logic [7:0] rst_count_q;
   logic [7:0] fs_count_q;
   // counts falling edges only, so a long assertion is one event
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_prev_q <= 1'b1;
         fs_prev_q <= 1'b1;
         rst_count_q <= 8'h00;
         fs_count_q <= 8'h00;
      end else begin
         rst_prev_q <= i_system_reset_out_n;
         fs_prev_q <= i_failsafe_out_n;
         if (rst_prev_q && !i_system_reset_out_n) begin
            rst_count_q <= rst_count_q + 8'h01;
         end
         if (fs_prev_q && !i_failsafe_out_n) begin
            fs_count_q <= fs_count_q + 8'h01;
         end
      end
   end
   assign o_rst_count = rst_count_q;
   assign o_fs_count = fs_count_q;
endmodule

// ### dv/io_and_hv_rail_supervisor_bench.sv
// io_and_hv_rail_supervisor_bench: apb register and fault reaction tests.
// assumes the 200 MHz clock and fixed deglitch counts of the package.
`timescale 1ns/10ps
module io_and_hv_rail_supervisor_bench;
   import rail_sup_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, rst_n, fs_n, irq;
   logic [3:0] cmp = 4'h0;
   logic [3:0] mask_v = 4'h5;
   logic [7:0] dac = 8'hA5;
   logic [6:0] reg_off;
   logic [3:0] th_io_ov, th_io_uv, th_hv_ov, th_hv_uv;
   logic io_nom, hv_nom, hv_track;
   logic [7:0] hv_ref, host_rst, host_fs;
   logic [31:0] exp_rst = 32'h0;
   logic [31:0] exp_fs = 32'h0;
   int failures = 0;
   int check_count = 0;
   int ucnt [4] = '{UV_C0, UV_C1, UV_C2, UV_C3};

   always #2.5 clk = ~clk;

   io_and_hv_rail_supervisor uut (.i_clk(clk), .i_resetn(resetn),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_io_ov_cmp(cmp[0]),
      .i_io_uv_cmp(cmp[1]), .i_hv_ov_cmp(cmp[2]), .i_hv_uv_cmp(cmp[3]),
      .i_core_dac(dac), .o_reg_off(reg_off),
      .o_system_reset_out_n(rst_n), .o_failsafe_out_n(fs_n), .o_irq(irq),
      .o_io_ov_threshold_code(th_io_ov), .o_io_uv_threshold_code(th_io_uv),
      .o_hv_ov_threshold_code(th_hv_ov), .o_hv_uv_threshold_code(th_hv_uv),
      .o_io_nominal_3v3(io_nom), .o_hv_nominal_3v3(hv_nom),
      .o_hv_track_dac(hv_track), .o_hv_reference(hv_ref));

   host_mcu_model host (.i_clk(clk), .i_resetn(resetn),
      .i_system_reset_out_n(rst_n), .i_failsafe_out_n(fs_n),
      .o_rst_count(host_rst), .o_fs_count(host_fs));

   task hold(input int n);
      repeat (n) @(posedge clk);
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // request held until pready is sampled high, then released
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // no wait count assumed; only the watchdog ends a stuck wait
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // raise comparator b for its deglitch count n, check reaction, clear
   task fault_check(input int b, input int n, input logic er,
                    input logic ef, input logic [6:0] eoff);
      cmp[b] <= 1'b1;
      hold(n - 5);
      chk({30'h0, rst_n, fs_n}, 32'h3);
      hold(10);
      chk({30'h0, rst_n, fs_n}, {30'h0, er, ef});
      chk({25'h0, reg_off}, {25'h0, eoff});
      chk({31'h0, irq}, {31'h0, mask_v[b]});
      apb(1'b0, ADDR_LIVE, 32'h0);
      chk(rd, {21'h0, eoff, 4'h0} | (32'h1 << b));
      cmp[b] <= 1'b0;
      hold(4);
      chk({23'h0, reg_off, rst_n, fs_n}, 32'h3);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rd, 32'h1 << b);
      apb(1'b1, ADDR_STAT, 32'hF);
      chk({31'h0, irq}, 32'h0);
      if (!er) exp_rst++;
      if (!ef) exp_fs++;
   endtask

   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      hold(4);
      resetn <= 1'b1;
      @(posedge clk);
      apb(1'b0, ADDR_CFG, 32'h0);
      chk(rd, CFG_RST);
      apb(1'b0, ADDR_REACT, 32'h0);
      chk(rd, REACT_RST);
      apb(1'b0, ADDR_THR, 32'h0);
      chk(rd, THR_RST);
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      // src 2, io 3.3 V, hv switch mode, hv 3.3 V asked but not allowed
      apb(1'b1, ADDR_CFG, 32'h0000_003A);
      chk({29'h0, io_nom, hv_track, hv_nom}, 32'h6);
      chk({24'h0, hv_ref}, 32'hA5);
      apb(1'b1, ADDR_CFG, 32'h0000_002A);
      chk({29'h0, io_nom, hv_track, hv_nom}, 32'h5);
      chk({24'h0, hv_ref}, 32'h0);
      apb(1'b1, ADDR_THR, 32'h0000_9A5F);
      chk({16'h0, th_hv_uv, th_hv_ov, th_io_uv, th_io_ov},
         32'h9A5F);
      apb(1'b1, ADDR_MASK, {28'h0, mask_v});
      apb(1'b0, ADDR_MASK, 32'h0);
      chk(rd, {28'h0, mask_v});
      // a glitch one short of the count must leave no trace
      cmp[0] <= 1'b1;
      hold(OV_C0 - 1);
      cmp[0] <= 1'b0;
      hold(2);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(rd, 32'h0);
      for (int r = 0; r < 4; r++) begin
         apb(1'b1, ADDR_REACT, (REACT_RST & ~32'h3) | r);
         fault_check(0, OV_C0, r < 2, r == 0, 7'h04);
      end
      apb(1'b1, ADDR_REACT, REACT_RST);
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, ADDR_CFG, 32'h2A | (s << CFG_IO_UVDG_LSB));
         fault_check(1, ucnt[s], 1'b1, 1'b0, 7'h00);
      end
      // external source, no pin reaction: flag only
      apb(1'b1, ADDR_CFG, {29'h0, SRC_EXT} | (32'h1 << CFG_IO_OVDG));
      apb(1'b1, ADDR_REACT, REACT_RST & ~32'h3);
      fault_check(0, OV_C1, 1'b1, 1'b1, 7'h00);
      apb(1'b1, ADDR_CFG, 32'h2A);
      apb(1'b1, ADDR_REACT, (REACT_RST & ~32'hC0) | 32'h80);
      fault_check(2, OV_C0, 1'b0, 1'b0, 7'h00);
      fault_check(3, UV_C0, 1'b0, 1'b0, 7'h00);
      chk({24'h0, host_rst}, exp_rst);
      chk({24'h0, host_fs}, exp_fs);
      // a second reset must bring the reaction fields back
      resetn <= 1'b0;
      hold(2);
      resetn <= 1'b1;
      @(posedge clk);
      apb(1'b0, ADDR_REACT, 32'h0);
      chk(rd, REACT_RST);
      wrap_up;
   end

   // tests need about 60000 cycles
   initial begin
      hold(80000);
      failures++;
      wrap_up;
   end
endmodule
